// *** common/prs_pkg.sv ***
// constants, types and one-hot states for the pull-range serial slave
// assumes consumers rtl/prs_i2c_pull_range_slave.sv plus the port checker and the bench
package prs_pkg;

  // own 7-bit device address default; device address selection is not modelled
  localparam logic [6:0] PRS_DEV_ADDR_DEFAULT = 7'h60;
  // register offset of the pull-range select register
  localparam logic [7:0] PRS_REG_PULL_RANGE = 8'h02;
  // register pointer value after reset and step per register transfer
  localparam logic [7:0] PRS_REG_PTR_RESET = 8'h00;
  localparam logic [7:0] PRS_REG_PTR_STEP = 8'h01;
  // reserved upper bits of the pull-range register read as this
  localparam logic [11:0] PRS_PULL_RSVD = 12'h000;
  // value returned for offsets with no register behind them
  localparam logic [15:0] PRS_UNMAPPED_READ = 16'h0000;
  // bit counting within a byte
  localparam logic [3:0] PRS_BIT_CNT_RESET = 4'h0;
  localparam logic [3:0] PRS_BIT_LAST = 4'h7;
  localparam logic [3:0] PRS_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] PRS_BIT_STEP = 4'h1;
  // highest serial bit rate the link logic is sized for, in kbit/s
  localparam int PRS_SCL_MAX_KBPS = 1000;

  // pull-range codes, ascending span
  typedef enum logic [3:0] {
    PRS_PPM_6P25 = 4'h0,
    PRS_PPM_10 = 4'h1,
    PRS_PPM_12P5 = 4'h2,
    PRS_PPM_25 = 4'h3,
    PRS_PPM_50 = 4'h4,
    PRS_PPM_80 = 4'h5,
    PRS_PPM_100 = 4'h6,
    PRS_PPM_125 = 4'h7,
    PRS_PPM_150 = 4'h8,
    PRS_PPM_200 = 4'h9,
    PRS_PPM_400 = 4'hA,
    PRS_PPM_600 = 4'hB,
    PRS_PPM_800 = 4'hC,
    PRS_PPM_1200 = 4'hD,
    PRS_PPM_1600 = 4'hE,
    PRS_PPM_3200 = 4'hF
  } prs_range_t;

  // factory value loaded at reset, overridable by parameter
  localparam prs_range_t PRS_FACTORY_RANGE = PRS_PPM_6P25;

  // link-side bus states, one-hot
  typedef enum logic [6:0] {
    PRS_ST_IDLE = 7'h01,
    PRS_ST_ADDR = 7'h02,
    PRS_ST_ADDR_ACK = 7'h04,
    PRS_ST_RX = 7'h08,
    PRS_ST_RX_ACK = 7'h10,
    PRS_ST_TX = 7'h20,
    PRS_ST_TX_ACK = 7'h40
  } prs_state_t;

  // register write carried from link domain to system domain
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] data;
  } prs_wr_t;

endpackage

// *** rtl/prs_i2c_pull_range_slave.sv ***
// two-wire slave giving an external master access to the pull-range register
// assumes scl/sda arrive raw from pins, link_clk oversamples them (>= 16x bit rate),
// sda is open drain with an external pull-up resolved outside this module
module prs_i2c_pull_range_slave
  import prs_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = prs_pkg::PRS_DEV_ADDR_DEFAULT,
  parameter prs_pkg::prs_range_t FACTORY_RANGE = prs_pkg::PRS_FACTORY_RANGE
) (
  // system clock domain
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // link clock, oversamples the serial pins
  input wire logic link_clk,
  // serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // selected pull range, system domain
  output prs_pkg::prs_range_t pull_range
);
  import prs_pkg::*;

  // link-domain synchronisers
  logic scl_m, scl_s, sda_m, sda_s;
  logic ce_m, ce_l, rst_m, link_rst;
  logic rd_ack_m, rd_ack_s;
  // link-domain state
  logic scl_d, sda_d;
  prs_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_sh, tx_sh;
  logic ack_on, rd_mode, addr_ok;
  logic have_ptr, byte_hi;
  logic [7:0] reg_ptr, wr_hi;
  logic [7:0] rd_addr;
  logic rd_req_tgl, rd_ack_d;
  logic [15:0] rd_word;
  prs_wr_t wr_bus;
  logic wr_req_tgl;
  // system-domain state
  logic wr_m, wr_s, wr_d;
  logic rq_m, rq_s, rq_d;
  logic [15:0] rd_data_x;
  logic rd_ack_tgl;
  // link-domain decodes, and the system-domain wr_evt and rd_evt
  logic scl_rise, scl_fall, start_det, stop_det;
  logic byte_end, addr_end, rx_end, tx_load;
  logic [7:0] next_byte, tx_byte;
  logic wr_evt, rd_evt, rd_ack_evt;

  // pins and reset/enable into the link domain, two flops each
  always_ff @(posedge link_clk) begin
    scl_m <= scl_i;
    scl_s <= scl_m;
    sda_m <= sda_i;
    sda_s <= sda_m;
    ce_m <= ce;
    ce_l <= ce_m;
    rst_m <= srst;
    link_rst <= rst_m;
    rd_ack_m <= rd_ack_tgl;
    rd_ack_s <= rd_ack_m;
  end

  // delayed copies of the synchronised lines for edge detection
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      rd_ack_d <= 1'b0;
    end else if (ce_l) begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      rd_ack_d <= rd_ack_s;
    end
  end

  // bus conditions; sda edges with scl high are start/stop, never data
  always_comb begin
    scl_rise = scl_s & ~scl_d;
    scl_fall = ~scl_s & scl_d;
    start_det = scl_s & scl_d & sda_d & ~sda_s;
    stop_det = scl_s & scl_d & ~sda_d & sda_s;
    rd_ack_evt = rd_ack_s ^ rd_ack_d;
  end

  // byte completion and transmit load strobes
  always_comb begin
    next_byte = {rx_sh[6:0], sda_s}; // msb first
    byte_end = scl_rise && (bit_cnt == PRS_BIT_LAST) &&
               (state == PRS_ST_ADDR || state == PRS_ST_RX);
    addr_end = byte_end && (state == PRS_ST_ADDR);
    rx_end = byte_end && (state == PRS_ST_RX);
    // a master nack moves on to the next byte; an ack ends the read
    tx_load = scl_fall && ((state == PRS_ST_ADDR_ACK && ack_on && rd_mode) ||
                           (state == PRS_ST_TX_ACK && !ack_on));
    tx_byte = byte_hi ? rd_word[15:8] : rd_word[7:0]; // high byte first
  end

  // data is only ever pulled low or let go
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // bus state machine; sda_oe changes only on scl falling edges
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state <= PRS_ST_IDLE;
      bit_cnt <= PRS_BIT_CNT_RESET;
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
      ack_on <= 1'b0;
      sda_oe <= 1'b0;
    end else if (ce_l) begin
      if (stop_det) begin
        state <= PRS_ST_IDLE;
        ack_on <= 1'b0;
        sda_oe <= 1'b0;
      end else if (start_det) begin
        state <= PRS_ST_ADDR;
        bit_cnt <= PRS_BIT_CNT_RESET;
        ack_on <= 1'b0;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          PRS_ST_ADDR, PRS_ST_RX: begin
            if (scl_rise) begin
              rx_sh <= next_byte;
              if (byte_end) begin
                bit_cnt <= PRS_BIT_CNT_RESET;
                state <= (state == PRS_ST_ADDR) ? PRS_ST_ADDR_ACK : PRS_ST_RX_ACK;
              end else begin
                bit_cnt <= bit_cnt + PRS_BIT_STEP;
              end
            end
          end
          PRS_ST_ADDR_ACK: begin
            if (scl_fall) begin
              if (!ack_on) begin
                if (addr_ok) begin
                  ack_on <= 1'b1;
                  sda_oe <= 1'b1;
                end else begin
                  // foreign address: stay off the bus until the next start
                  state <= PRS_ST_IDLE;
                  sda_oe <= 1'b0;
                end
              end else if (rd_mode) begin
                ack_on <= 1'b0;
                state <= PRS_ST_TX;
                bit_cnt <= PRS_BIT_CNT_RESET;
                sda_oe <= ~tx_byte[7];
                tx_sh <= {tx_byte[6:0], 1'b0};
              end else begin
                ack_on <= 1'b0;
                state <= PRS_ST_RX;
                sda_oe <= 1'b0;
              end
            end
          end
          PRS_ST_RX_ACK: begin
            if (scl_fall) begin
              if (!ack_on) begin
                ack_on <= 1'b1;
                sda_oe <= 1'b1; // every data byte is acked
              end else begin
                ack_on <= 1'b0;
                state <= PRS_ST_RX;
                sda_oe <= 1'b0;
              end
            end
          end
          PRS_ST_TX: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + PRS_BIT_STEP;
            end else if (scl_fall) begin
              if (bit_cnt == PRS_BITS_PER_BYTE) begin
                state <= PRS_ST_TX_ACK;
                sda_oe <= 1'b0; // let the master drive its ack
              end else begin
                sda_oe <= ~tx_sh[7]; // zero pulls low, one releases
                tx_sh <= {tx_sh[6:0], 1'b0};
              end
            end
          end
          PRS_ST_TX_ACK: begin
            // ack_on here holds the master's answer, low sda means ack
            if (scl_rise) begin
              ack_on <= ~sda_s;
            end else if (scl_fall && ack_on) begin
              // acked: let go so the master can stop or restart
              ack_on <= 1'b0;
              state <= PRS_ST_IDLE;
              sda_oe <= 1'b0;
            end else if (tx_load) begin
              // a low first bit holds sda and so blocks stop/restart
              state <= PRS_ST_TX;
              bit_cnt <= PRS_BIT_CNT_RESET;
              sda_oe <= ~tx_byte[7];
              tx_sh <= {tx_byte[6:0], 1'b0};
            end
          end
          PRS_ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          default: begin
            state <= PRS_ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // address byte: 7-bit address then direction, one means read
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      rd_mode <= 1'b0;
      addr_ok <= 1'b0;
    end else if (ce_l && addr_end) begin
      rd_mode <= next_byte[0];
      addr_ok <= (next_byte[7:1] == DEV_ADDR);
    end
  end

  // register pointer, write assembly and read prefetch requests
  // pointer survives between transfers so a bare read resumes there
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      reg_ptr <= PRS_REG_PTR_RESET;
      have_ptr <= 1'b0;
      byte_hi <= 1'b1;
      wr_hi <= 8'h00;
      wr_bus <= '0;
      wr_req_tgl <= 1'b0;
      rd_addr <= PRS_REG_PTR_RESET;
      rd_req_tgl <= 1'b0;
    end else if (ce_l) begin
      if (start_det) begin
        // a half-written register is dropped at any start
        have_ptr <= 1'b0;
        byte_hi <= 1'b1;
      end else if (addr_end) begin
        if (next_byte[7:1] == DEV_ADDR && next_byte[0]) begin
          // fetch early: the word is needed once the ack bit ends
          rd_addr <= reg_ptr;
          rd_req_tgl <= ~rd_req_tgl;
        end
      end else if (rx_end && addr_ok) begin
        if (!have_ptr) begin
          reg_ptr <= next_byte;
          have_ptr <= 1'b1;
        end else if (byte_hi) begin
          wr_hi <= next_byte;
          byte_hi <= 1'b0;
        end else begin
          wr_bus.addr <= reg_ptr;
          wr_bus.data <= {wr_hi, next_byte};
          wr_req_tgl <= ~wr_req_tgl;
          reg_ptr <= reg_ptr + PRS_REG_PTR_STEP; // wraps 255 to 0
          byte_hi <= 1'b1;
        end
      end else if (tx_load) begin
        if (byte_hi) begin
          byte_hi <= 1'b0;
        end else begin
          // low byte is now in the shifter, so the word may be refetched
          byte_hi <= 1'b1;
          reg_ptr <= reg_ptr + PRS_REG_PTR_STEP;
          rd_addr <= reg_ptr + PRS_REG_PTR_STEP;
          rd_req_tgl <= ~rd_req_tgl;
        end
      end
    end
  end

  // read word returned from the system domain
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      rd_word <= PRS_UNMAPPED_READ;
    end else if (ce_l && rd_ack_evt) begin
      rd_word <= rd_data_x;
    end
  end

  // toggles from the link domain, two flops plus one for the edge
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_m <= 1'b0;
      wr_s <= 1'b0;
      wr_d <= 1'b0;
      rq_m <= 1'b0;
      rq_s <= 1'b0;
      rq_d <= 1'b0;
    end else if (ce) begin
      wr_m <= wr_req_tgl;
      wr_s <= wr_m;
      wr_d <= wr_s;
      rq_m <= rd_req_tgl;
      rq_s <= rq_m;
      rq_d <= rq_s;
    end
  end

  // wr_bus and rd_addr are held stable from their toggle until well past it
  always_comb begin
    wr_evt = wr_s ^ wr_d;
    rd_evt = rq_s ^ rq_d;
  end

  // pull-range register: factory code at reset, low four bits writable
  always_ff @(posedge clk) begin
    if (srst) begin
      pull_range <= FACTORY_RANGE;
    end else if (ce && wr_evt && wr_bus.addr == PRS_REG_PULL_RANGE) begin
      // upper bits of the written word are discarded
      pull_range <= prs_range_t'(wr_bus.data[3:0]);
    end
  end

  // read answer, handed back with a toggle; other offsets read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data_x <= PRS_UNMAPPED_READ;
      rd_ack_tgl <= 1'b0;
    end else if (ce && rd_evt) begin
      if (rd_addr == PRS_REG_PULL_RANGE) begin
        rd_data_x <= {PRS_PULL_RSVD, pull_range};
      end else begin
        rd_data_x <= PRS_UNMAPPED_READ;
      end
      rd_ack_tgl <= ~rd_ack_tgl;
    end
  end

endmodule

// *** tb/prs_chk_sva.sv ***
// port checker for the pull-range serial slave
// assumes bind onto prs_i2c_pull_range_slave, sda wired-and with a pull-up
module prs_chk_sva
  import prs_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = prs_pkg::PRS_DEV_ADDR_DEFAULT,
  parameter prs_pkg::prs_range_t FACTORY_RANGE = prs_pkg::PRS_FACTORY_RANGE
) (
  // system domain
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // link domain and pins
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire prs_pkg::prs_range_t pull_range
);
  logic [7:0] lo_cnt;
  logic [7:0] hi_cnt;
  logic [7:0] idle_cnt;

  // scl phase lengths in link cycles, saturating so they never wrap
  always_ff @(posedge link_clk) begin
    lo_cnt <= scl_i ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hFF};
    hi_cnt <= !scl_i ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hFF};
  end

  // idle bus time in system cycles
  always_ff @(posedge clk) begin
    idle_cnt <= (srst || !scl_i || !sda_i) ? 8'h00 : idle_cnt + {7'h00, idle_cnt != 8'hFF};
  end

  chk_out_low: assert property (@(posedge link_clk) disable iff (srst) sda_o == 1'b0)
    else $error("sda_o not low");
  chk_range_reset: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> pull_range == FACTORY_RANGE) else $error("range not factory value");
  chk_range_idle: assert property (@(posedge clk) disable iff (srst)
    idle_cnt > 8'h64 |-> $stable(pull_range)) else $error("range moved on idle bus");
  chk_oe_rise: assert property (@(posedge link_clk) disable iff (srst)
    $rose(sda_oe) |-> !scl_i) else $error("sda pulled while scl high");
  chk_oe_fall: assert property (@(posedge link_clk) disable iff (srst)
    $fell(sda_oe) |-> !scl_i) else $error("sda released while scl high");
  chk_oe_hold: assert property (@(posedge link_clk) disable iff (srst)
    $rose(sda_oe) |=> sda_oe [*8]) else $error("low level not held");
  chk_oe_late: assert property (@(posedge link_clk) disable iff (srst)
    $changed(sda_oe) |-> lo_cnt <= 8'h08) else $error("sda change late in low phase");
  chk_idle_rel: assert property (@(posedge link_clk) disable iff (srst)
    hi_cnt >= 8'h1E |-> !sda_oe) else $error("sda held on idle bus");

  cov_low: cover property (@(posedge link_clk) $rose(sda_oe));
  cov_write: cover property (@(posedge clk) $changed(pull_range));
  cov_idle: cover property (@(posedge clk) idle_cnt == 8'h65);
endmodule

bind prs_i2c_pull_range_slave prs_chk_sva #(
  .DEV_ADDR(DEV_ADDR),
  .FACTORY_RANGE(FACTORY_RANGE)
) u_chk (
  .clk(clk), .srst(srst), .ce(ce), .link_clk(link_clk), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .pull_range(pull_range)
);

// *** tb/prs_i2c_master_model.sv ***
// behavioural two-wire bus master
// assumes pull-ups outside; sda_w is the resolved data wire
module prs_i2c_master_model (
  // pacing clock
  input wire logic clk,
  // bus lines, 1 on sda_drv means released
  output logic scl,
  output logic sda_drv,
  input wire logic sda_w
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // quarter bit of 250 ns, a 1 us bit
  task automatic qw();
    repeat (10) @(posedge clk);
  endtask

  // sda moves a quarter into scl low, sampled mid high
  task automatic xbit(input logic b, output logic r);
    qw();
    sda_drv <= b;
    qw();
    scl <= 1'b1;
    qw();
    r = sda_w;
    qw();
    scl <= 1'b0;
  endtask

  // start or repeated start from either scl level
  task automatic start();
    qw();
    sda_drv <= 1'b1;
    qw();
    scl <= 1'b1;
    qw();
    sda_drv <= 1'b0;
    qw();
    scl <= 1'b0;
  endtask

  // stop, then both lines left released
  task automatic stop();
    qw();
    sda_drv <= 1'b0;
    qw();
    scl <= 1'b1;
    qw();
    sda_drv <= 1'b1;
    qw();
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
    end
    xbit(1'b1, r);
    ack = ~r;
  endtask

  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, d[i]);
    end
    xbit(~ack, r);
  endtask
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the pull-range serial slave
// assumes the master model and checker are compiled before it
module testbench
  import prs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam prs_range_t FR = PRS_PPM_125;
  localparam logic [6:0] DEV = PRS_DEV_ADDR_DEFAULT;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic scl;
  logic sda_drv;
  logic sda_o;
  logic sda_oe;
  logic sda_w;
  prs_range_t pull_range;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [15:0] w;
  logic a;

  always #12.5 clk = ~clk;
  // link clock, phase unrelated to clk
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  // wired-and with pull-up
  assign sda_w = sda_drv & ~sda_oe;

  prs_i2c_pull_range_slave #(.FACTORY_RANGE(FR)) dut (
    .clk(clk), .srst(srst), .ce(ce), .link_clk(link_clk), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .pull_range(pull_range)
  );
  prs_i2c_master_model m (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda_w(sda_w));

  task automatic final_report();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t word %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_a(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t ack %b expected %b", $time, g, e);
    end
  endtask

  task automatic addr(input logic [6:0] dv, input logic rd, input logic e);
    m.wbyte({dv, rd}, a);
    chk_a(a, e);
  endtask

  task automatic wr8(input logic [7:0] d);
    m.wbyte(d, a);
    chk_a(a, 1'b1);
  endtask

  // high byte first; a nack asks for more, an ack on the low byte ends the read
  task automatic rd16(input logic last, input logic [15:0] e);
    m.rbyte(1'b0, w[15:8]);
    m.rbyte(last, w[7:0]);
    chk_w(w, e);
  endtask

  // hang guard, the run needs about 62k cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (10) @(posedge clk);
    chk_w({12'h000, pull_range}, {12'h000, FR});
    // read without pointer write walks up from zero
    m.start();
    addr(DEV, 1'b1, 1'b1);
    rd16(1'b0, 16'h0000);
    rd16(1'b0, 16'h0000);
    rd16(1'b1, {12'h000, FR});
    m.stop();
    m.start();
    addr(DEV ^ 7'h01, 1'b0, 1'b0);
    m.stop();
    // every code, junk in the upper bits, read back after restarts
    for (int c = 0; c < 16; c++) begin
      m.start();
      addr(DEV, 1'b0, 1'b1);
      wr8(PRS_REG_PULL_RANGE);
      wr8(8'hAB);
      wr8({4'hC, 4'(c)});
      chk_w({12'h000, pull_range}, {12'h000, 4'(c)});
      m.start();
      addr(DEV, 1'b0, 1'b1);
      wr8(PRS_REG_PULL_RANGE);
      m.start();
      addr(DEV, 1'b1, 1'b1);
      rd16(1'b1, {12'h000, 4'(c)});
      m.stop();
    end
    // pointer parked at the top must wrap to zero
    m.start();
    addr(DEV, 1'b0, 1'b1);
    wr8(8'hFF);
    m.stop();
    m.start();
    addr(DEV, 1'b1, 1'b1);
    rd16(1'b0, 16'h0000);
    rd16(1'b0, 16'h0000);
    rd16(1'b0, 16'h0000);
    rd16(1'b1, 16'h000F);
    m.stop();
    // enable low freezes the slave: no ack and the range is kept
    ce <= 1'b0;
    m.start();
    addr(DEV, 1'b0, 1'b0);
    m.stop();
    ce <= 1'b1;
    repeat (150) @(posedge clk);
    chk_w({12'h000, pull_range}, 16'h000F);
    final_report();
  end
endmodule
